// [logic/axrp_addr_step.sv]
`default_nettype none
`include "axrp_consts.svh"
module axrp_addr_step
    import axrp_pkg::*;
(
    input  wire logic [`AXRP_NATIVE_AW-1:0] i_addr,
    input  wire logic [2:0]                 i_size,
    input  wire logic [1:0]                 i_burst,
    input  wire logic [`AXRP_LEN_W-1:0]     i_len,
    output logic      [`AXRP_NATIVE_AW-1:0] o_next
);
    logic [`AXRP_NATIVE_AW-1:0] step;
    logic [`AXRP_NATIVE_AW-1:0] span;
    logic [`AXRP_NATIVE_AW-1:0] incr;
    assign step = `AXRP_NATIVE_AW'(1) << i_size;
    assign span = `AXRP_NATIVE_AW'({4'h0, i_len} + 12'h001) << i_size;
    assign incr = i_addr + step;
    // wrap keeps the address inside the aligned span of the burst
    always_comb begin
        case (i_burst)
            `AXRP_BURST_FIXED: o_next = i_addr;
            `AXRP_BURST_WRAP:  o_next = (i_addr & ~(span - 12'h001)) | (incr & (span - 12'h001));
            default:           o_next = incr;
        endcase
    end
endmodule : axrp_addr_step
`default_nettype wire

// [logic/axrp_consts.svh]
`ifndef AXRP_CONSTS_SVH
`define AXRP_CONSTS_SVH
// ************************************************************
// widths
// ************************************************************
`define AXRP_ID_W        4
`define AXRP_ADDR_W      64
`define AXRP_NATIVE_AW   12
`define AXRP_DATA_W      32
`define AXRP_LEN_W       8
`define AXRP_MEM_WORDS   1024
`define AXRP_WIDX_W      10
// ************************************************************
// response codes and burst kinds
// ************************************************************
`define AXRP_RESP_OKAY   2'h0
`define AXRP_RESP_EXOKAY 2'h1
`define AXRP_RESP_SLVERR 2'h2
`define AXRP_BURST_FIXED 2'h0
`define AXRP_BURST_INCR  2'h1
`define AXRP_BURST_WRAP  2'h2
`define AXRP_WRAP_LEN    8'h0F
// ************************************************************
// recommended attribute values
// ************************************************************
`define AXRP_CACHE_REC   4'h3
`define AXRP_PROT_REC    3'h0
`endif

// [logic/axrp_endpoint.sv]
`default_nettype none
`include "axrp_consts.svh"
module axrp_endpoint
    import axrp_pkg::*;
#(
    parameter bit HAS_READ  = 1'b1,
    parameter bit HAS_WRITE = 1'b1
) (
    input  wire logic                    i_mclk,
    input  wire logic                    i_reset_n,
    // write address and data, kept minimal for the response path
    input  wire logic                    i_awvalid,
    output logic                         o_awready,
    input  wire axrp_areq_s              i_aw,
    input  wire logic                    i_wvalid,
    output logic                         o_wready,
    input  wire logic [`AXRP_DATA_W-1:0] i_wdata,
    input  wire logic [3:0]              i_wstrb,
    input  wire logic                    i_wlast,
    // write response
    output logic                         o_bvalid,
    input  wire logic                    i_bready,
    output axrp_bresp_s                  o_b,
    // read address
    input  wire logic                    i_arvalid,
    output logic                         o_arready,
    input  wire axrp_areq_s              i_ar,
    // read data
    output logic                         o_rvalid,
    input  wire logic                    i_rready,
    output axrp_rbeat_s                  o_r
);
    // ************************************************************
    // storage
    // ************************************************************
    function automatic logic [`AXRP_WIDX_W-1:0] word_of(input logic [`AXRP_NATIVE_AW-1:0] a);
        word_of = a[`AXRP_NATIVE_AW-1:2];
    endfunction : word_of

    function automatic logic bad_req(input axrp_areq_s q);
        // lock is ignored: no exclusive monitor, plain okay answer
        bad_req = (q.size > 3'h2) || (q.burst == 2'h3) ||
                  ((q.burst == `AXRP_BURST_WRAP) && (q.len != `AXRP_WRAP_LEN) && (q.len != 8'h01) &&
                   (q.len != 8'h03) && (q.len != 8'h07));
    endfunction : bad_req

    // ************************************************************
    // write path
    // ************************************************************
    logic                       w_act;
    logic                       w_err;
    logic [`AXRP_ID_W-1:0]      w_id;
    logic [`AXRP_NATIVE_AW-1:0] w_addr;
    logic [`AXRP_NATIVE_AW-1:0] w_next;
    logic [2:0]                 w_size;
    logic [1:0]                 w_burst;
    logic [`AXRP_LEN_W-1:0]     w_len;
    logic                       w_busy;
    logic                       w_beat;
    logic                       w_done;

    assign o_awready = HAS_WRITE && !w_act && !w_busy;
    assign o_wready  = HAS_WRITE && w_act;
    assign w_beat    = i_wvalid && o_wready;
    assign w_done    = w_beat && i_wlast;

    axrp_addr_step u_wstep (
        .i_addr  (w_addr),
        .i_size  (w_size),
        .i_burst (w_burst),
        .i_len   (w_len),
        .o_next  (w_next)
    );

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            w_act <= 1'b0;
        end else if (i_awvalid && o_awready) begin
            w_act <= 1'b1;
        end else if (w_done) begin
            w_act <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            w_id    <= '0;
            w_addr  <= '0;
            w_size  <= 3'h0;
            w_burst <= 2'h0;
            w_len   <= '0;
            w_err   <= 1'b0;
        end else if (i_awvalid && o_awready) begin
            w_id    <= i_aw.id;
            w_addr  <= i_aw.addr[`AXRP_NATIVE_AW-1:0];
            w_size  <= i_aw.size;
            w_burst <= i_aw.burst;
            w_len   <= i_aw.len;
            w_err   <= bad_req(i_aw);
        end else if (w_beat) begin
            w_addr  <= w_next;
        end
    end

    generate
        if (HAS_WRITE) begin : g_wresp
            axrp_wr_resp u_wresp (
                .i_mclk    (i_mclk),
                .i_reset_n (i_reset_n),
                .i_done    (w_done),
                .i_id      (w_id),
                .i_err     (w_err),
                .o_busy    (w_busy),
                .o_bvalid  (o_bvalid),
                .i_bready  (i_bready),
                .o_b       (o_b)
            );
        end else begin : g_nowresp
            // write channels absent: response stays idle
            assign w_busy   = 1'b0;
            assign o_bvalid = 1'b0;
            assign o_b      = '0;
        end
    endgenerate

    // ************************************************************
    // read path
    // ************************************************************
    // cache attribute is not decoded
    // protection attribute is not decoded
    // quality of service is not decoded
    // region is accepted and left unused
    // no user bits on response or read data
    axrp_rd_e                   rd_state;
    logic [`AXRP_ID_W-1:0]      r_id;
    logic [`AXRP_NATIVE_AW-1:0] r_addr;
    logic [`AXRP_NATIVE_AW-1:0] r_next;
    logic [2:0]                 r_size;
    logic [1:0]                 r_burst;
    logic [`AXRP_LEN_W-1:0]     r_len;
    logic [`AXRP_LEN_W-1:0]     r_left;
    logic                       r_err;
    logic                       r_take;

    assign o_arready = HAS_READ && (rd_state == AXRP_RD_IDLE);
    assign r_take    = i_arvalid && o_arready;
    assign o_rvalid  = (rd_state == AXRP_RD_SEND);

    axrp_addr_step u_rstep (
        .i_addr  (r_addr),
        .i_size  (r_size),
        .i_burst (r_burst),
        .i_len   (r_len),
        .o_next  (r_next)
    );

    // one array per byte lane, so each lane has a single writer
    logic [`AXRP_DATA_W-1:0] rd_word;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            logic [7:0] lane_mem [0:`AXRP_MEM_WORDS-1];
            always_ff @(posedge i_mclk) begin
                if (w_beat && !w_err && i_wstrb[g]) begin
                    lane_mem[word_of(w_addr)] <= i_wdata[8*g +: 8];
                end
            end
            assign rd_word[8*g +: 8] = lane_mem[word_of(r_addr)];
        end
    endgenerate

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rd_state <= AXRP_RD_IDLE;
        end else begin
            case (rd_state)
                AXRP_RD_IDLE: begin
                    if (r_take) begin
                        rd_state <= AXRP_RD_READ;
                    end
                end
                AXRP_RD_READ: begin
                    rd_state <= AXRP_RD_SEND;
                end
                AXRP_RD_SEND: begin
                    if (i_rready) begin
                        rd_state <= (r_left == '0) ? AXRP_RD_IDLE : AXRP_RD_READ;
                    end
                end
                default: begin
                    rd_state <= AXRP_RD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r_id    <= '0;
            r_addr  <= '0;
            r_size  <= 3'h0;
            r_burst <= 2'h0;
            r_len   <= '0;
            r_left  <= '0;
            r_err   <= 1'b0;
        end else if (r_take) begin
            r_id    <= i_ar.id;
            r_addr  <= i_ar.addr[`AXRP_NATIVE_AW-1:0];
            r_size  <= i_ar.size;
            r_burst <= i_ar.burst;
            r_len   <= i_ar.len;
            r_left  <= i_ar.len;
            r_err   <= bad_req(i_ar);
        end else if (o_rvalid && i_rready) begin
            r_addr  <= r_next;
            r_left  <= r_left - 8'h01;
        end
    end

    // beat payload registered, held until accepted
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_r <= '0;
        end else if (rd_state == AXRP_RD_READ) begin
            o_r.id   <= r_id;
            o_r.data <= r_err ? '0 : rd_word;
            o_r.resp <= r_err ? `AXRP_RESP_SLVERR : `AXRP_RESP_OKAY;
            o_r.last <= (r_left == '0);
        end
    end
endmodule : axrp_endpoint
`default_nettype wire

// [logic/axrp_pkg.sv]
`default_nettype none
`include "axrp_consts.svh"
package axrp_pkg;
    typedef struct packed {
        logic [`AXRP_ID_W-1:0]   id;
        logic [`AXRP_ADDR_W-1:0] addr;
        logic [`AXRP_LEN_W-1:0]  len;
        logic [2:0]              size;
        logic [1:0]              burst;
        logic                    lock;
        logic [3:0]              cache;
        logic [2:0]              prot;
        logic [3:0]              qos;
        logic [3:0]              region;
    } axrp_areq_s;
    typedef struct packed {
        logic [`AXRP_ID_W-1:0]   id;
        logic [`AXRP_DATA_W-1:0] data;
        logic [1:0]              resp;
        logic                    last;
    } axrp_rbeat_s;
    typedef struct packed {
        logic [`AXRP_ID_W-1:0]   id;
        logic [1:0]              resp;
    } axrp_bresp_s;
    typedef enum logic [1:0] {
        AXRP_RD_IDLE,
        AXRP_RD_READ,
        AXRP_RD_SEND
    } axrp_rd_e;
endpackage : axrp_pkg
`default_nettype wire

// [logic/axrp_wr_resp.sv]
`default_nettype none
`include "axrp_consts.svh"
module axrp_wr_resp
    import axrp_pkg::*;
(
    input  wire logic                  i_mclk,
    input  wire logic                  i_reset_n,
    input  wire logic                  i_done,
    input  wire logic [`AXRP_ID_W-1:0] i_id,
    input  wire logic                  i_err,
    output logic                       o_busy,
    output logic                       o_bvalid,
    input  wire logic                  i_bready,
    output axrp_bresp_s                o_b
);
    // one pending response; the write side stalls while it is held
    assign o_busy = o_bvalid;
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_bvalid <= 1'b0;
        end else if (i_done) begin
            o_bvalid <= 1'b1;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_b <= '0;
        end else if (i_done) begin
            o_b.id   <= i_id;
            o_b.resp <= i_err ? `AXRP_RESP_SLVERR : `AXRP_RESP_OKAY;
        end
    end
endmodule : axrp_wr_resp
`default_nettype wire

// [tb/axi_read_and_write_response_profile_tb.sv]
`default_nettype none
`include "axrp_consts.svh"
module axi_read_and_write_response_profile_tb
    import axrp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_mclk, i_reset_n, i_awvalid, o_awready, i_wvalid, o_wready, i_wlast, o_bvalid, i_bready;
    logic        i_arvalid, o_arready, o_rvalid, i_rready;
    axrp_areq_s  i_aw, i_ar;
    logic [31:0] i_wdata, seed, sseed;
    logic [3:0]  i_wstrb;
    logic [1:0]  stall;
    axrp_bresp_s o_b;
    axrp_rbeat_s o_r;
    logic        ro_awready, ro_wready, ro_bvalid, wo_arready, wo_rvalid;
    axrp_bresp_s wo_b;
    logic [31:0] mem [1024];
    axrp_rbeat_s rq[$];
    axrp_bresp_s bq[$];
    int          n_fail, checked;
    axrp_endpoint dut_u (.i_mclk, .i_reset_n, .i_awvalid, .o_awready, .i_aw, .i_wvalid, .o_wready, .i_wdata,
        .i_wstrb, .i_wlast, .o_bvalid, .i_bready, .o_b, .i_arvalid, .o_arready, .i_ar, .o_rvalid, .i_rready, .o_r);
    axrp_master_model mm_u (.i_mclk, .i_reset_n, .i_stall(stall), .o_rready(i_rready), .o_bready(i_bready));
    // read-only and write-only builds share the stimulus; their absent channels must stay idle
    axrp_endpoint #(.HAS_WRITE(1'b0)) ro_u (.i_mclk, .i_reset_n, .i_awvalid, .o_awready(ro_awready), .i_aw,
        .i_wvalid, .o_wready(ro_wready), .i_wdata, .i_wstrb, .i_wlast, .o_bvalid(ro_bvalid), .i_bready, .o_b(),
        .i_arvalid(1'b0), .o_arready(), .i_ar, .o_rvalid(), .i_rready, .o_r());
    axrp_endpoint #(.HAS_READ(1'b0)) wo_u (.i_mclk, .i_reset_n, .i_awvalid, .o_awready(), .i_aw, .i_wvalid,
        .o_wready(), .i_wdata, .i_wstrb, .i_wlast, .o_bvalid(), .i_bready, .o_b(wo_b), .i_arvalid,
        .o_arready(wo_arready), .i_ar, .o_rvalid(wo_rvalid), .i_rready, .o_r());
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [11:0] nxt(input logic [11:0] a, input axrp_areq_s q);
        logic [11:0] m;
        m = {2'b00, q.len, 2'b11};
        if (q.burst == `AXRP_BURST_FIXED) return a;
        if (q.burst == `AXRP_BURST_WRAP) return (a & ~m) | ((a + 12'h004) & m);
        return a + 12'h004;
    endfunction : nxt
    function automatic axrp_areq_s req(input logic [3:0] id, input logic [63:0] ad, input logic [7:0] ln,
                                       input logic [1:0] bu, input logic [2:0] sz);
        axrp_areq_s q;
        q = axrp_areq_s'({seed, seed, seed, seed[0]});
        q.id = id;
        q.addr = ad;
        q.len = ln;
        q.burst = bu;
        q.size = sz;
        return q;
    endfunction : req
    task automatic cmp_r(input axrp_rbeat_s e, input axrp_rbeat_s g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED at %0t: read beat exp %h got %h", $time, e, g);
        end
    endtask : cmp_r
    task automatic cmp_b(input axrp_bresp_s e, input axrp_bresp_s g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED at %0t: write resp exp %h got %h", $time, e, g);
        end
    endtask : cmp_b
    task automatic cmp_off(input logic [2:0] g);
        checked++;
        if (g !== 3'h0) begin
            n_fail++;
            $display("CHECK FAILED at %0t: absent channel exp %h got %h", $time, 3'h0, g);
        end
    endtask : cmp_off
    task automatic drain();
        repeat (3000) if (rq.size() + bq.size() != 0) @(negedge i_mclk);
        if (rq.size() + bq.size() != 0) n_fail++;
        @(posedge i_mclk);
    endtask : drain
    task automatic wr(input axrp_areq_s q, input bit full);
        logic [11:0] a;
        logic [3:0]  s;
        a = q.addr[11:0];
        i_aw <= q;
        i_awvalid <= 1'b1;
        do @(negedge i_mclk); while (!o_awready);
        @(posedge i_mclk);
        i_awvalid <= 1'b0;
        for (int i = 0; i <= q.len; i++) begin
            seed = lfsr(seed);
            s = full ? 4'hF : seed[7:4];
            i_wdata <= seed;
            i_wstrb <= s;
            i_wlast <= (i == q.len);
            i_wvalid <= 1'b1;
            do @(negedge i_mclk); while (!o_wready);
            for (int k = 0; k < 4; k++) if (s[k]) mem[a[11:2]][k*8+:8] = seed[k*8+:8];
            @(posedge i_mclk);
            a = nxt(a, q);
        end
        i_wvalid <= 1'b0;
        bq.push_back('{id: q.id, resp: `AXRP_RESP_OKAY});
        drain();
    endtask : wr
    task automatic rd(input axrp_areq_s q);
        logic [11:0] a;
        logic        bad;
        a = q.addr[11:0];
        bad = q.size > 3'h2;
        i_ar <= q;
        i_arvalid <= 1'b1;
        do @(negedge i_mclk); while (!o_arready);
        for (int i = 0; i <= q.len; i++) begin
            rq.push_back('{id: q.id, data: bad ? 32'h0 : mem[a[11:2]],
                           resp: bad ? `AXRP_RESP_SLVERR : `AXRP_RESP_OKAY, last: i == q.len});
            a = nxt(a, q);
        end
        @(posedge i_mclk);
        i_arvalid <= 1'b0;
        drain();
    endtask : rd
    task automatic complete_run();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    // ************************************************************
    // clock, stalls, monitor, watchdog
    // ************************************************************
    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        sseed <= lfsr(sseed);
        stall <= sseed[1:0];
    end
    always @(negedge i_mclk) begin
        if (o_rvalid && i_rready) cmp_r(rq.pop_front(), o_r);
        if (o_bvalid && i_bready) cmp_b(bq[0], wo_b);
        if (o_bvalid && i_bready) cmp_b(bq.pop_front(), o_b);
        cmp_off({ro_awready, ro_wready, ro_bvalid});
        cmp_off({1'b0, wo_arready, wo_rvalid});
    end
    initial begin
        repeat (20000) @(posedge i_mclk);
        n_fail++;
        complete_run();
    end
    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        {i_reset_n, i_awvalid, i_wvalid, i_wlast, i_arvalid, i_wdata, i_wstrb, i_aw, i_ar, stall} = '0;
        seed = 32'h26;
        sseed = 32'h26;
        n_fail = 0;
        checked = 0;
        repeat (4) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        @(posedge i_mclk);
        wr(req(4'h3, 64'h0, 8'hFF, `AXRP_BURST_INCR, 3'h2), 1'b1);
        rd(req(4'h6, 64'hFFFF_0000_0000_F000, 8'hFF, `AXRP_BURST_INCR, 3'h2));
        wr(req(4'h5, 64'h208, 8'h0F, `AXRP_BURST_WRAP, 3'h2), 1'b0);
        wr(req(4'h2, 64'h104, 8'h03, `AXRP_BURST_FIXED, 3'h2), 1'b0);
        for (int j = 0; j < 4; j++) rd(req(4'(j), 64'h23C, 8'((2 << j) - 1), `AXRP_BURST_WRAP, 3'h2));
        for (int j = 0; j < 16; j++) rd(req(4'(j), 64'(j * 4 + 256), 8'h0, `AXRP_BURST_INCR, 3'h2));
        rd(req(4'hA, 64'h104, 8'h02, `AXRP_BURST_FIXED, 3'h2));
        rd(req(4'hC, 64'h100, 8'h01, `AXRP_BURST_INCR, 3'h3));
        complete_run();
    end
endmodule : axi_read_and_write_response_profile_tb
`default_nettype wire

// [tb/axrp_endpoint_properties.sv]
`default_nettype none
`include "axrp_consts.svh"
module axrp_endpoint_properties
    import axrp_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_reset_n,
    input  wire logic        i_awvalid,
    input  wire logic        o_awready,
    input  wire axrp_areq_s  i_aw,
    input  wire logic        i_wvalid,
    input  wire logic        o_wready,
    input  wire logic        i_wlast,
    input  wire logic        o_bvalid,
    input  wire logic        i_bready,
    input  wire axrp_bresp_s o_b,
    input  wire logic        i_arvalid,
    input  wire logic        o_arready,
    input  wire axrp_areq_s  i_ar,
    input  wire logic        o_rvalid,
    input  wire logic        i_rready,
    input  wire axrp_rbeat_s o_r
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [`AXRP_ID_W-1:0]  rid;
    logic [`AXRP_ID_W-1:0]  wid;
    logic [`AXRP_LEN_W-1:0] rlen;
    logic [`AXRP_LEN_W-1:0] nbeat;
    // ************************************************************
    // request capture and beat counting
    // ************************************************************
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rid  <= '0;
            rlen <= '0;
        end else if (i_arvalid && o_arready) begin
            rid  <= i_ar.id;
            rlen <= i_ar.len;
        end
    end
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wid <= '0;
        end else if (i_awvalid && o_awready) begin
            wid <= i_aw.id;
        end
    end
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            nbeat <= '0;
        end else if (i_arvalid && o_arready) begin
            nbeat <= '0;
        end else if (o_rvalid && i_rready) begin
            nbeat <= nbeat + 1'b1;
        end
    end
    // ************************************************************
    // properties
    // ************************************************************
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    sequence ar_take;
        i_arvalid && o_arready;
    endsequence
    sequence w_end;
        i_wvalid && o_wready && i_wlast;
    endsequence
    sequence beat_gap;
        !o_rvalid ##1 o_rvalid;
    endsequence
    rd_first_beat_a: assert property (ar_take |=> beat_gap) else $error("first read beat late");
    rd_next_beat_a: assert property (o_rvalid && i_rready && !o_r.last |=> beat_gap)
        else $error("next read beat late");
    rd_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_r)) else $error("beat dropped");
    b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_b)) else $error("resp dropped");
    wr_resp_id_a: assert property (w_end |=> o_bvalid && o_b.id == wid) else $error("write resp wrong");
    rd_id_echo_a: assert property (o_rvalid |-> o_r.id == rid) else $error("read id wrong");
    r_resp_legal_a: assert property (o_rvalid |-> o_r.resp != `AXRP_RESP_EXOKAY) else $error("read exokay");
    b_resp_legal_a: assert property (o_bvalid |-> o_b.resp != `AXRP_RESP_EXOKAY) else $error("write exokay");
    rd_last_beat_a: assert property (o_rvalid |-> o_r.last == (nbeat == rlen)) else $error("last misplaced");
    ar_blocked_a: assert property (o_rvalid |-> !o_arready) else $error("read taken in burst");
endmodule : axrp_endpoint_properties
bind axrp_endpoint axrp_endpoint_properties chk_u (
    .i_mclk, .i_reset_n, .i_awvalid, .o_awready, .i_aw, .i_wvalid, .o_wready, .i_wlast,
    .o_bvalid, .i_bready, .o_b, .i_arvalid, .o_arready, .i_ar, .o_rvalid, .i_rready, .o_r
);
`default_nettype wire

// [tb/axrp_master_model.sv]
`default_nettype none
module axrp_master_model (
    input  wire logic       i_mclk,
    input  wire logic       i_reset_n,
    input  wire logic [1:0] i_stall,
    output logic            o_rready,
    output logic            o_bready
);
    timeunit 1ns;
    timeprecision 1ps;
    // ready moves only after an edge, so a stalled beat must sit still
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rready <= 1'b0;
            o_bready <= 1'b0;
        end else begin
            o_rready <= !i_stall[0];
            o_bready <= !i_stall[1];
        end
    end
endmodule : axrp_master_model
`default_nettype wire
